// >>> pkg/irw_pkg.sv
// package: constants and types shared by both ends of the register write port
package irw_pkg;
	// link framing
	localparam logic [7:0] SLAVE_ADDR     = 8'h8C;
	localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
	localparam logic [3:0] ACK_SLOT       = 4'h8;
	localparam logic [3:0] FIRST_BIT_CNT  = 4'h1;
	localparam int         MSB_POS        = 7;
	// register holding the power sequencing bits
	localparam logic [7:0] SUB_POWER      = 8'h0D;
	localparam int         STANDBY_POS    = 0;
	localparam int         SOFT_START_RELEASE_BIT_POS     = 1;
	localparam int         REG_COUNT      = 16;
	// timing
	localparam int         REF_CLK_HZ     = 10_000_000;
	localparam int         SCL_MAX_KHZ    = 400;
	localparam int         HZ_PER_KHZ     = 1000;
	localparam int         PHASES_PER_BIT = 4;
	localparam int         SCL_QTR_CYC    = (REF_CLK_HZ + PHASES_PER_BIT * SCL_MAX_KHZ *
		HZ_PER_KHZ - 1) / (PHASES_PER_BIT * SCL_MAX_KHZ * HZ_PER_KHZ);
	// byte position within a frame and quarter phase within a bit, as seen by the master
	localparam logic [1:0] BYTE_ADDR      = 2'h0;
	localparam logic [1:0] BYTE_SUB       = 2'h1;
	localparam logic [1:0] BYTE_DATA      = 2'h2;
	localparam logic [1:0] PHASE_HIGH     = 2'h1;
	localparam logic [1:0] PHASE_FALL     = 2'h2;
	localparam logic [1:0] PHASE_LAST     = 2'h3;

	typedef enum logic [1:0] {
		DEV_IDLE,
		DEV_ADDR,
		DEV_SUB,
		DEV_DATA
	} irw_dev_state_t;

	typedef enum logic [2:0] {
		HOST_IDLE,
		HOST_START,
		HOST_BIT,
		HOST_ACK,
		HOST_WAIT,
		HOST_STOP
	} irw_host_state_t;
endpackage

// >>> pkg/irw_link_if.sv
`timescale 1ns/1ps
// interface: two-wire link between the bus master and the register write port
interface irw_link_if;
	logic scl;
	logic mst_sda_out;
	logic mst_sda_oe_n;
	logic slv_sda_out;
	logic slv_sda_oe_n;
	logic sda;

	// wired-and with pull-up: a released driver reads as high
	assign sda = (mst_sda_oe_n | mst_sda_out) & (slv_sda_oe_n | slv_sda_out);

	modport master (
		output scl,
		output mst_sda_out,
		output mst_sda_oe_n,
		input  sda
	);

	modport slave (
		input  scl,
		input  sda,
		output slv_sda_out,
		output slv_sda_oe_n
	);
endinterface

// >>> logic/irw_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for levels entering a clock domain
module irw_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// level from another domain and its synchronised copy
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} irw_sync_st_t;

	irw_sync_st_t st_ff;
	irw_sync_st_t nxt_st;

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.meta = d;
		nxt_st.sync = st_ff.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.sync;
endmodule

// >>> logic/irw_slave.sv
`timescale 1ns/1ps
// device end: write-only two-wire slave feeding the control register file
// Operation
// - start, address, subaddress, data, acks, then stop
// - answer only slave address 1000 1100
// - withhold every ack while power is bad
// - data bytes never advance the subaddress
// - accept serial clock up to 400 kHz
// - register contents undefined after power-up
// - master presets all registers before soft start
// - master times geometry changes into vertical blanking
// - slow master may delay last byte or bit
// - master sends all functions sharing a register
// - protection clears standby and soft-start bits
module irw_slave #(
	parameter int REGS = irw_pkg::REG_COUNT
) (
	// system clock and reset
	input  wire logic            ref_clk,
	input  wire logic            reset_n,
	// two-wire link
	irw_link_if.slave            link,
	// supervisor inputs, asynchronous
	input  wire logic            power_good,
	input  wire logic            protect_evt,
	// register read port
	input  wire logic [$clog2(REGS)-1:0] rd_addr,
	output logic      [7:0]      rd_data,
	// write notification
	output logic                 wr_strobe,
	output logic      [7:0]      wr_addr,
	output logic      [7:0]      wr_data,
	// power sequencing bits
	output logic                 standby_bit,
	output logic                 soft_start_bit
);
	localparam int IDX_W = $clog2(REGS);

	// link domain state, clocked by the serial clock
	typedef struct packed {
		irw_pkg::irw_dev_state_t state;
		logic [3:0]              bit_cnt;
		logic [7:0]              shift;
		logic [7:0]              subaddr;
		logic                    ack_want;
		logic                    start_seen;
		logic                    stop_seen;
		logic                    wr_tgl;
		logic [7:0]              wr_addr;
		logic [7:0]              wr_data;
	} irw_link_st_t;

	// system domain state
	typedef struct packed {
		logic       wr_seen;
		logic       wr_strobe;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic [7:0] rd_data;
		logic       standby;
		logic       soft_start;
	} irw_user_st_t;

	irw_link_st_t ln_ff;
	irw_link_st_t nxt_ln;
	irw_user_st_t us_ff;
	irw_user_st_t nxt_us;

	logic       start_tgl_ff;
	logic       stop_tgl_ff;
	logic       ack_drive_ff;
	logic       pg_s;
	logic       wr_tgl_s;
	logic       prot_s;
	logic       start_pend;
	logic       stop_pend;
	logic       new_wr;
	logic [7:0] shifted;
	logic [7:0] reg_file [REGS];

	function automatic logic in_range(input logic [7:0] sub);
		in_range = (32'(sub) < REGS);
	endfunction

	// start and stop are the only sda edges while scl is high; they are caught
	// on sda itself since scl stands still around them
	always_ff @(negedge link.sda or negedge reset_n) begin
		if (!reset_n) begin
			start_tgl_ff <= 1'b0;
		end else if (link.scl) begin
			start_tgl_ff <= ~start_tgl_ff;
		end
	end

	always_ff @(posedge link.sda or negedge reset_n) begin
		if (!reset_n) begin
			stop_tgl_ff <= 1'b0;
		end else if (link.scl) begin
			stop_tgl_ff <= ~stop_tgl_ff;
		end
	end

	// power-good is resampled on scl so a bad supply is seen within two bits
	irw_sync #(
		.WIDTH (1)
	) u_pg_sync (
		.clk   (link.scl),
		.rst_n (reset_n),
		.d     (power_good),
		.q     (pg_s)
	);

	// the toggles settle a setup time before the next scl rise, which the
	// protocol guarantees, so the link logic may compare them directly
	assign start_pend = start_tgl_ff != ln_ff.start_seen;
	assign stop_pend  = stop_tgl_ff != ln_ff.stop_seen;
	assign shifted    = {ln_ff.shift[6:0], link.sda};

	// no clock divider or filter sits on scl, so any rate within fast mode works
	always_comb begin
		nxt_ln = ln_ff;
		if (start_pend) begin
			nxt_ln.state      = irw_pkg::DEV_ADDR;
			nxt_ln.bit_cnt    = irw_pkg::FIRST_BIT_CNT;
			nxt_ln.shift      = shifted;
			nxt_ln.ack_want   = 1'b0;
			nxt_ln.start_seen = start_tgl_ff;
			nxt_ln.stop_seen  = stop_tgl_ff;
		end else if (stop_pend) begin
			nxt_ln.state     = irw_pkg::DEV_IDLE;
			nxt_ln.bit_cnt   = '0;
			nxt_ln.ack_want  = 1'b0;
			nxt_ln.stop_seen = stop_tgl_ff;
		end else if (ln_ff.state != irw_pkg::DEV_IDLE) begin
			if (ln_ff.bit_cnt == irw_pkg::ACK_SLOT) begin
				nxt_ln.bit_cnt  = '0;
				nxt_ln.ack_want = 1'b0;
				if (!ln_ff.ack_want) begin
					nxt_ln.state = irw_pkg::DEV_IDLE;
				end else begin
					case (ln_ff.state)
						irw_pkg::DEV_ADDR: begin
							nxt_ln.state = irw_pkg::DEV_SUB;
						end
						irw_pkg::DEV_SUB: begin
							nxt_ln.subaddr = ln_ff.shift;
							nxt_ln.state   = irw_pkg::DEV_DATA;
						end
						irw_pkg::DEV_DATA: begin
							nxt_ln.wr_tgl  = ~ln_ff.wr_tgl;
							nxt_ln.wr_addr = ln_ff.subaddr;
							nxt_ln.wr_data = ln_ff.shift;
						end
						default: begin
							nxt_ln.state = irw_pkg::DEV_IDLE;
						end
					endcase
				end
			end else begin
				nxt_ln.shift   = shifted;
				nxt_ln.bit_cnt = ln_ff.bit_cnt + 4'h1;
				if (ln_ff.bit_cnt == irw_pkg::LAST_DATA_BIT) begin
					nxt_ln.ack_want = pg_s &&
						(ln_ff.state != irw_pkg::DEV_ADDR ||
						shifted == irw_pkg::SLAVE_ADDR);
				end
			end
		end
	end

	always_ff @(posedge link.scl or negedge reset_n) begin
		if (!reset_n) begin
			ln_ff <= '0;
		end else begin
			ln_ff <= nxt_ln;
		end
	end

	// ack changes sda only while scl is low, hence the falling edge
	always_ff @(negedge link.scl or negedge reset_n) begin
		if (!reset_n) begin
			ack_drive_ff <= 1'b0;
		end else begin
			ack_drive_ff <= ln_ff.ack_want && ln_ff.bit_cnt == irw_pkg::ACK_SLOT;
		end
	end

	assign link.slv_sda_out  = 1'b0;
	assign link.slv_sda_oe_n = ~ack_drive_ff;

	// write event crosses as a toggle; address and data stay put for a whole
	// byte time, far longer than the three system cycles the crossing needs
	irw_sync #(
		.WIDTH (2)
	) u_user_sync (
		.clk   (ref_clk),
		.rst_n (reset_n),
		.d     ({ln_ff.wr_tgl, protect_evt}),
		.q     ({wr_tgl_s, prot_s})
	);

	assign new_wr = wr_tgl_s != us_ff.wr_seen;

	always_comb begin
		nxt_us           = us_ff;
		nxt_us.wr_seen   = wr_tgl_s;
		nxt_us.wr_strobe = new_wr;
		nxt_us.rd_data   = reg_file[rd_addr];
		if (new_wr) begin
			nxt_us.wr_addr = ln_ff.wr_addr;
			nxt_us.wr_data = ln_ff.wr_data;
			if (ln_ff.wr_addr == irw_pkg::SUB_POWER) begin
				nxt_us.standby    = ln_ff.wr_data[irw_pkg::STANDBY_POS];
				nxt_us.soft_start = ln_ff.wr_data[irw_pkg::SOFT_START_RELEASE_BIT_POS];
			end
		end
		// protection beats a write landing in the same cycle: safe state first
		if (prot_s) begin
			nxt_us.standby    = 1'b0;
			nxt_us.soft_start = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			us_ff <= '0;
		end else begin
			us_ff <= nxt_us;
		end
	end

	// contents come up random, so software must preset every entry
	always_ff @(posedge ref_clk) begin
		if (new_wr && in_range(ln_ff.wr_addr)) begin
			reg_file[ln_ff.wr_addr[IDX_W-1:0]] <= ln_ff.wr_data;
		end
	end

	assign rd_data        = us_ff.rd_data;
	assign wr_strobe      = us_ff.wr_strobe;
	assign wr_addr        = us_ff.wr_addr;
	assign wr_data        = us_ff.wr_data;
	assign standby_bit    = us_ff.standby;
	assign soft_start_bit = us_ff.soft_start;
endmodule

// >>> logic/irw_master.sv
`timescale 1ns/1ps
// far end: bus master that writes one subaddress with one or more data bytes
module irw_master #(
	parameter int QTR_CYC = irw_pkg::SCL_QTR_CYC
) (
	// system clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// two-wire link
	irw_link_if.master      link,
	// write requests
	input  wire logic       wr_valid,
	output logic            wr_ready,
	input  wire logic [7:0] wr_subaddr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_last,
	// asynchronous permit for the final bit, high inside vertical blanking
	input  wire logic       update_gate,
	// status
	output logic            busy,
	output logic            done,
	output logic            nack
);
	localparam int CW = $clog2(QTR_CYC + 1);
	localparam logic [CW-1:0] QTR_END = CW'(QTR_CYC - 1);

	typedef struct packed {
		irw_pkg::irw_host_state_t state;
		logic [1:0]               phase;
		logic [CW-1:0]            tick_cnt;
		logic [2:0]               bit_cnt;
		logic [1:0]               byte_idx;
		logic [7:0]               shift;
		logic [7:0]               hold_sub;
		logic [7:0]               hold_data;
		logic                     last;
		logic                     scl;
		logic                     sda_low;
		logic                     done;
		logic                     nack;
	} irw_host_st_t;

	irw_host_st_t st_ff;
	irw_host_st_t nxt_st;
	logic         sda_s;
	logic         gate_s;
	logic         take;
	logic         tick;
	logic         stall;

	irw_sync #(
		.WIDTH (2)
	) u_in_sync (
		.clk   (ref_clk),
		.rst_n (reset_n),
		.d     ({link.sda, update_gate}),
		.q     ({sda_s, gate_s})
	);

	assign wr_ready = st_ff.state == irw_pkg::HOST_IDLE || st_ff.state == irw_pkg::HOST_WAIT;
	assign take     = wr_valid && wr_ready;
	assign tick     = st_ff.tick_cnt == QTR_END;
	// holding scl low before the final bit defers the register update
	assign stall    = st_ff.state == irw_pkg::HOST_BIT && st_ff.byte_idx == irw_pkg::BYTE_DATA &&
		st_ff.last && st_ff.bit_cnt == irw_pkg::LAST_DATA_BIT[2:0] && st_ff.phase == '0 &&
		!gate_s;

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		if (take) begin
			nxt_st.tick_cnt  = '0;
			nxt_st.phase     = '0;
			nxt_st.bit_cnt   = '0;
			nxt_st.hold_data = wr_data;
			nxt_st.last      = wr_last;
			if (st_ff.state == irw_pkg::HOST_IDLE) begin
				nxt_st.state    = irw_pkg::HOST_START;
				nxt_st.byte_idx = irw_pkg::BYTE_ADDR;
				nxt_st.shift    = irw_pkg::SLAVE_ADDR;
				nxt_st.hold_sub = wr_subaddr;
				nxt_st.nack     = 1'b0;
			end else begin
				nxt_st.state   = irw_pkg::HOST_BIT;
				nxt_st.shift   = wr_data;
				nxt_st.sda_low = ~wr_data[irw_pkg::MSB_POS];
			end
		end else if (wr_ready || stall) begin
			nxt_st.tick_cnt = '0;
		end else if (!tick) begin
			nxt_st.tick_cnt = st_ff.tick_cnt + CW'(1);
		end else begin
			nxt_st.tick_cnt = '0;
			nxt_st.phase    = st_ff.phase + 2'h1;
			case (st_ff.state)
				irw_pkg::HOST_START: begin
					if (st_ff.phase == '0) begin
						nxt_st.sda_low = 1'b1;
					end else if (st_ff.phase == irw_pkg::PHASE_HIGH) begin
						nxt_st.scl = 1'b0;
					end else if (st_ff.phase == irw_pkg::PHASE_LAST) begin
						nxt_st.state   = irw_pkg::HOST_BIT;
						nxt_st.sda_low = ~st_ff.shift[irw_pkg::MSB_POS];
					end
				end
				irw_pkg::HOST_BIT: begin
					if (st_ff.phase == '0) begin
						nxt_st.scl = 1'b1;
					end else if (st_ff.phase == irw_pkg::PHASE_FALL) begin
						nxt_st.scl = 1'b0;
					end else if (st_ff.phase == irw_pkg::PHASE_LAST) begin
						nxt_st.shift   = {st_ff.shift[6:0], 1'b0};
						nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
						nxt_st.sda_low = ~st_ff.shift[irw_pkg::MSB_POS - 1];
						if (st_ff.bit_cnt == irw_pkg::LAST_DATA_BIT[2:0]) begin
							nxt_st.state   = irw_pkg::HOST_ACK;
							nxt_st.sda_low = 1'b0;
						end
					end
				end
				irw_pkg::HOST_ACK: begin
					if (st_ff.phase == '0) begin
						nxt_st.scl = 1'b1;
					end else if (st_ff.phase == irw_pkg::PHASE_HIGH) begin
						nxt_st.nack = sda_s;
					end else if (st_ff.phase == irw_pkg::PHASE_FALL) begin
						nxt_st.scl = 1'b0;
					end else if (st_ff.nack || (st_ff.byte_idx == irw_pkg::BYTE_DATA &&
						st_ff.last)) begin
						nxt_st.state   = irw_pkg::HOST_STOP;
						nxt_st.sda_low = 1'b1;
					end else if (st_ff.byte_idx == irw_pkg::BYTE_DATA) begin
						nxt_st.state = irw_pkg::HOST_WAIT;
					end else begin
						nxt_st.state    = irw_pkg::HOST_BIT;
						nxt_st.byte_idx = st_ff.byte_idx + 2'h1;
						nxt_st.shift    = (st_ff.byte_idx == irw_pkg::BYTE_ADDR) ?
							st_ff.hold_sub : st_ff.hold_data;
						nxt_st.sda_low  = ~nxt_st.shift[irw_pkg::MSB_POS];
					end
				end
				irw_pkg::HOST_STOP: begin
					if (st_ff.phase == '0) begin
						nxt_st.scl = 1'b1;
					end else if (st_ff.phase == irw_pkg::PHASE_HIGH) begin
						nxt_st.sda_low = 1'b0;
					end else if (st_ff.phase == irw_pkg::PHASE_LAST) begin
						nxt_st.state = irw_pkg::HOST_IDLE;
						nxt_st.done  = 1'b1;
					end
				end
				default: begin
					nxt_st.state = irw_pkg::HOST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff     <= '0;
			st_ff.scl <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign link.scl          = st_ff.scl;
	assign link.mst_sda_out  = 1'b0;
	assign link.mst_sda_oe_n = ~st_ff.sda_low;
	assign busy              = st_ff.state != irw_pkg::HOST_IDLE;
	assign done              = st_ff.done;
	assign nack              = st_ff.nack;
endmodule

// >>> logic/irw_master_fix.sv
`timescale 1ns/1ps
// spare design unit slot: no logic lives here

// >>> verification/irw_link_properties.sv
// checker: framing, acknowledge and clock timing relations on the two-wire link
`timescale 1ns/1ps
module irw_link_properties (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// link signals
	input wire logic scl,
	input wire logic sda,
	input wire logic mst_sda_oe_n,
	input wire logic slv_sda_oe_n,
	// supervisor level
	input wire logic power_good
);
	logic       scl_ff;
	logic       sda_ff;
	logic       pg_ff;
	logic       first_ff;
	logic [3:0] bit_ff;
	logic [7:0] shift_ff;
	logic [2:0] pg_cnt_ff;
	logic       rise;
	logic       start;

	assign rise  = scl & ~scl_ff;
	assign start = scl & scl_ff & sda_ff & ~sda;

	// bit position since start; bit_ff of 8 marks the acknowledge slot
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_ff    <= 1'b1;
			sda_ff    <= 1'b1;
			pg_ff     <= 1'b1;
			first_ff  <= 1'b0;
			bit_ff    <= 4'h0;
			shift_ff  <= 8'h00;
			pg_cnt_ff <= 3'h0;
		end else begin
			scl_ff <= scl;
			sda_ff <= sda;
			pg_ff  <= power_good;
			// rises seen at a steady supply level; the slave syncs it on scl only
			if (pg_ff != power_good) begin
				pg_cnt_ff <= 3'h0;
			end else if (rise && pg_cnt_ff != 3'h5) begin
				pg_cnt_ff <= pg_cnt_ff + 3'h1;
			end
			if (start) begin
				bit_ff   <= 4'h0;
				first_ff <= 1'b1;
			end else if (rise && bit_ff == 4'h8) begin
				bit_ff   <= 4'h0;
				first_ff <= 1'b0;
			end else if (rise) begin
				bit_ff   <= bit_ff + 4'h1;
				shift_ff <= {shift_ff[6:0], sda};
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	sequence s_ack_rise;
		rise && bit_ff == 4'h8;
	endsequence
	sequence s_addr_ack;
		s_ack_rise ##0 first_ff;
	endsequence

	property p_scl_high_min;
		$rose(scl) |-> scl[*4];
	endproperty
	// low phase check is one cycle shorter than the two quarters the master holds scl low at least
	property p_scl_low_min;
		$fell(scl) |-> !scl[*3];
	endproperty
	property p_master_releases_ack;
		s_ack_rise |-> mst_sda_oe_n;
	endproperty
	property p_ack_only_in_slot;
		rise && bit_ff != 4'h8 |-> slv_sda_oe_n;
	endproperty
	property p_ack_changes_scl_low;
		$changed(slv_sda_oe_n) |-> !scl;
	endproperty
	property p_addr_value;
		s_addr_ack |-> shift_ff == irw_pkg::SLAVE_ADDR;
	endproperty
	property p_addr_acked;
		s_addr_ack ##0 (power_good && pg_cnt_ff == 3'h5) |-> !slv_sda_oe_n;
	endproperty
	property p_no_ack_bad_power;
		rise && !power_good && pg_cnt_ff == 3'h5 |-> slv_sda_oe_n;
	endproperty

	a_scl_high_min: assert property (p_scl_high_min)
		else $error("scl high phase too short");
	a_scl_low_min: assert property (p_scl_low_min)
		else $error("scl low phase too short");
	a_master_releases_ack: assert property (p_master_releases_ack)
		else $error("master drives sda in ack slot");
	a_ack_only_in_slot: assert property (p_ack_only_in_slot)
		else $error("slave drives sda outside ack slot");
	a_ack_changes_scl_low: assert property (p_ack_changes_scl_low)
		else $error("slave sda changed while scl high");
	a_addr_value: assert property (p_addr_value)
		else $error("address byte is not the slave address");
	a_addr_acked: assert property (p_addr_acked)
		else $error("own address not acknowledged");
	a_no_ack_bad_power: assert property (p_no_ack_bad_power)
		else $error("acknowledge given with supply bad");
endmodule

// >>> verification/tb_i2c_register_write_port.sv
// testbench: master and register write port joined over the two-wire link
`timescale 1ns/1ps
module tb_i2c_register_write_port;
	logic       ref_clk;
	logic       reset_n;
	logic       power_good;
	logic       protect_evt;
	logic [3:0] rd_addr;
	logic [7:0] rd_data;
	logic       wr_strobe;
	logic [7:0] wr_addr;
	logic [7:0] s_data;
	logic       standby_bit;
	logic       soft_start_bit;
	logic       wr_valid;
	logic       wr_ready;
	logic [7:0] wr_subaddr;
	logic [7:0] m_data;
	logic       wr_last;
	logic       update_gate;
	logic       busy;
	logic       done;
	logic       nack;
	logic       s2_strobe;
	logic       acked;
	logic [1:0] pw_bits;
	logic [7:0] exp_sub;
	logic [7:0] shadow [16];
	logic [15:0] known;
	int         bad_count;
	int         comparisons;
	int         strobes;
	int         strobes2;

	irw_link_if link ();
	irw_link_if link_b ();

	irw_slave u_irw_slave (.ref_clk, .reset_n, .link(link.slave), .power_good, .protect_evt,
		.rd_addr, .rd_data, .wr_strobe, .wr_addr, .wr_data(s_data), .standby_bit,
		.soft_start_bit);
	// second slave faces a bench driver that breaks the framing on purpose
	irw_slave u_irw_slave_2 (.ref_clk, .reset_n, .link(link_b.slave), .power_good,
		.protect_evt, .rd_addr, .rd_data(), .wr_strobe(s2_strobe), .wr_addr(), .wr_data(),
		.standby_bit(), .soft_start_bit());
	irw_master #(.QTR_CYC(2)) u_irw_master (.ref_clk, .reset_n, .link(link.master), .wr_valid,
		.wr_ready, .wr_subaddr, .wr_data(m_data), .wr_last, .update_gate, .busy, .done, .nack);
	irw_link_properties u_irw_link_properties (.ref_clk, .reset_n, .scl(link.scl),
		.sda(link.sda), .mst_sda_oe_n(link.mst_sda_oe_n), .slv_sda_oe_n(link.slv_sda_oe_n),
		.power_good);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	function automatic logic [1:0] power_bits(input logic [7:0] d);
		return {d[irw_pkg::SOFT_START_RELEASE_BIT_POS], d[irw_pkg::STANDBY_POS]};
	endfunction

	task automatic summarize;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	always @(posedge ref_clk) begin
		if (wr_strobe === 1'b1) begin
			strobes++;
			chk(wr_addr, exp_sub);
		end
		if (s2_strobe === 1'b1) begin
			strobes2++;
		end
	end

	task automatic wait_sig(input logic want_ready);
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
			if (n > 5000) begin
				bad_count++;
				summarize();
			end
		end while (want_ready ? wr_ready !== 1'b1 : done !== 1'b1);
	endtask

	task automatic send(input logic [7:0] sub, input logic [7:0] d, input logic last);
		@(posedge ref_clk);
		wr_valid   <= 1'b1;
		wr_subaddr <= sub;
		m_data     <= d;
		wr_last    <= last;
		wait_sig(1'b1);
		@(posedge ref_clk);
		wr_valid <= 1'b0;
	endtask

	task automatic frame(input logic [7:0] sub, input int n, input logic ok, input logic hold);
		logic [7:0] d;
		int s0;
		s0 = strobes;
		exp_sub = sub;
		for (int k = 0; k < n; k++) begin
			d = 8'($urandom);
			if (sub == irw_pkg::SUB_POWER) d[1:0] = pw_bits;
			if (k == n - 1 && hold) update_gate <= 1'b0;
			send(sub, d, k == n - 1);
		end
		if (hold) begin
			repeat (300) @(posedge ref_clk);
			chk(busy, 1'b1);
			chk(8'(strobes - s0), 8'(n - 1));
			update_gate <= 1'b1;
		end
		wait_sig(1'b0);
		repeat (4) @(posedge ref_clk);
		chk(nack, 8'(!ok));
		chk(8'(strobes - s0), ok ? 8'(n) : 8'h00);
		if (ok) begin
			chk(s_data, d);
			if (sub < 8'h10) shadow[sub[3:0]] = d;
			if (sub < 8'h10) known[sub[3:0]] = 1'b1;
		end
		if (ok && sub == irw_pkg::SUB_POWER) chk({soft_start_bit, standby_bit}, power_bits(d));
		rd_addr <= sub[3:0];
		repeat (2) @(posedge ref_clk);
		if (sub < 8'h10 && known[sub[3:0]]) chk(rd_data, shadow[sub[3:0]]);
	endtask

	task automatic bb_bit(input logic b);
		@(posedge ref_clk);
		link_b.mst_sda_oe_n <= b;
		repeat (2) @(posedge ref_clk);
		link_b.scl <= 1'b1;
		repeat (3) @(posedge ref_clk);
		acked = ~link_b.sda;
		@(posedge ref_clk);
		link_b.scl <= 1'b0;
	endtask

	task automatic bb_edge(input logic stop);
		@(posedge ref_clk);
		link_b.mst_sda_oe_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		link_b.scl <= stop;
		repeat (2) @(posedge ref_clk);
		link_b.mst_sda_oe_n <= 1'b1;
	endtask

	task automatic bb_byte(input logic [7:0] v, input int nb);
		for (int i = 7; i > 7 - nb; i--) bb_bit(v[i]);
		if (nb == 8) bb_bit(1'b1);
	endtask

	initial begin
		reset_n = 1'b0;
		power_good = 1'b1;
		protect_evt = 1'b0;
		rd_addr = 4'h0;
		wr_valid = 1'b0;
		wr_subaddr = 8'h00;
		m_data = 8'h00;
		wr_last = 1'b0;
		update_gate = 1'b1;
		pw_bits = 2'h0;
		exp_sub = 8'h00;
		known = 16'h0000;
		bad_count = 0;
		comparisons = 0;
		strobes = 0;
		strobes2 = 0;
		link_b.scl = 1'b1;
		link_b.mst_sda_oe_n = 1'b1;
		link_b.mst_sda_out = 1'b0;
		void'($urandom(17));
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		// every entry gets a known value while soft start is still held off
		for (int r = 0; r < 16; r++) frame(8'(r), 1, 1'b1, 1'b0);
		// every standby and soft-start combination
		for (int p = 0; p < 4; p++) begin
			pw_bits = 2'(p);
			frame(irw_pkg::SUB_POWER, 1, 1'b1, 1'b0);
		end
		frame(8'h0F, 1, 1'b1, 1'b0);
		frame(8'h10, 1, 1'b1, 1'b0);
		for (int i = 1; i < 5; i++) frame(8'($urandom % 16), i, 1'b1, i == 4);
		power_good <= 1'b0;
		frame(irw_pkg::SUB_POWER, 1, 1'b0, 1'b0);
		power_good <= 1'b1;
		protect_evt <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk({soft_start_bit, standby_bit}, 8'h00);
		protect_evt <= 1'b0;
		bb_edge(1'b0);
		bb_byte(8'h8D, 8);
		chk(acked, 1'b0);
		bb_byte(8'h05, 8);
		bb_byte(8'hA5, 8);
		chk(acked, 1'b0);
		bb_edge(1'b1);
		bb_edge(1'b0);
		bb_byte(irw_pkg::SLAVE_ADDR, 8);
		chk(acked, 1'b1);
		bb_byte(8'h05, 8);
		bb_byte(8'h3C, 4);
		bb_edge(1'b1);
		repeat (8) @(posedge ref_clk);
		chk(8'(strobes2), 8'h00);
		bb_edge(1'b0);
		bb_byte(irw_pkg::SLAVE_ADDR, 8);
		bb_byte(8'h05, 8);
		bb_byte(8'h3C, 8);
		chk(acked, 1'b1);
		bb_edge(1'b1);
		repeat (8) @(posedge ref_clk);
		chk(8'(strobes2), 8'h01);
		summarize();
	end
endmodule
